// File: bench/raa_checker.sv
// concurrent checks on the host port between controller and random access space
`timescale 1ns/1ps
module raa_checker
    import raa_pkg::*;
(
    input wire logic        hclk,    // clock
    input wire logic        hresetn, // async reset, low
    input wire logic        req,     // host request
    input wire logic        write,   // direction
    input wire logic [8:0]  addr,    // word address
    input wire logic [31:0] wdata,   // write data, watched only
    input wire logic        ack,     // completion pulse
    input wire logic [31:0] rdata    // read data
);
    // ********************
    // host port properties
    // ********************
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    // gaps and debug words answer zero, so one wire covers them all
    wire zero_zone = (addr[8:7] == 2'b11) || (addr[8:4] == 5'h0B) || (addr[8:4] == 5'h0F);
    ack_single_a: assert property (ack |=> !ack)
        else $error("ack stood longer than one cycle");
    ack_cause_a: assert property (ack |-> $past(req))
        else $error("ack without a request");
    req_release_a: assert property (ack |=> !req)
        else $error("request kept after ack");
    // the whole request, data included, must stand until the answer
    req_hold_a: assert property (req && !ack |=> (req || ack) && $stable(addr) &&
        $stable(write) && $stable(wdata)) else $error("request moved before ack");
    ack_bound_a: assert property ($rose(req) |-> ##[1:200] ack)
        else $error("request never answered");
    rdata_hold_a: assert property ($changed(rdata) |-> ack)
        else $error("read data moved without ack");
    empty_read_a: assert property (ack && !$past(write) && $past(zero_zone) |->
        rdata == 32'h0000_0000) else $error("empty word read not zero");
    size_read_a: assert property (ack && !$past(write) && $past(addr) == STAT_LO |->
        rdata == 32'(CODE_BYTES - REV_BYTES)) else $error("code size word wrong");
endmodule

// File: bench/tb.sv
// self-checking bench: AHB host controller and random access space face each other
`timescale 1ns/1ps
module tb;
    import raa_pkg::*;
    // ********************************
    // wiring, stimulus regs and tables
    // ********************************
    logic        hclk, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, four_wire = 1'b0;
    logic        boot_load = 1'b0, rom_req_ack = 1'b0, front_req = 1'b0, front_we = 1'b0;
    logic        cpu_req = 1'b0, cpu_we = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic [8:0]  front_addr = 9'h000, cpu_addr = 9'h000;
    logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, front_wdata = 32'h0000_0000;
    logic [31:0] cpu_wdata = 32'h0000_0000, rd;
    logic [31:0] boot_user_rev = 32'h0102_0304, boot_vend_rev = 32'h0506_0708;
    wire  [31:0] hrdata, cpu_rdata, proc_request;
    wire         hready, cpu_host_start;
    wire  [1:0]  owner;
    int          fail_count = 0, total_checks = 0;
    // rows 0-14 are read-write, 15-23 read zero, 24 is the code size word
    logic [8:0]  row_addr [25] = '{9'h000, 9'h0AF, 9'h0C0, 9'h0CF, 9'h0DF, 9'h100, 9'h11F,
        9'h120, 9'h16B, 9'h16C, 9'h17B, 9'h17C, 9'h17D, 9'h17E, 9'h17F, 9'h0B0, 9'h0F0,
        9'h0F8, 9'h0FB, 9'h0FC, 9'h180, 9'h1FF, 9'h0E1, 9'h0E3, 9'h0E0};
    logic [8:0]  fe_addr [4] = '{9'h080, 9'h08A, 9'h000, 9'h09B};
    host_port_if hp_bus ();
    // the two ends meet across hp_bus; the checker watches that link
    random_access_area_map i_random_access_area_map (.hclk, .hresetn, .hp(hp_bus), .front_req,
        .front_we, .front_addr, .front_wdata, .four_wire, .cpu_req, .cpu_we, .cpu_addr,
        .cpu_wdata, .cpu_rdata, .cpu_host_start, .boot_load, .boot_user_rev, .boot_vend_rev,
        .rom_req_ack, .proc_request, .owner);
    raa_host_ctrl i_raa_host_ctrl (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hwdata, .hready, .hrdata, .hreadyout(hready), .hresp(), .hp(hp_bus));
    raa_checker i_raa_checker (.hclk, .hresetn, .req(hp_bus.req), .write(hp_bus.write),
        .addr(hp_bus.addr), .wdata(hp_bus.wdata), .ack(hp_bus.ack), .rdata(hp_bus.rdata));
    // 100 MHz clock
    initial
    begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    // ********************
    // shared tasks
    // ********************
    function automatic logic [31:0] pat(input logic [8:0] a);
        return {16'hA5C3, 7'h00, a};
    endfunction
    task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string m);
        total_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("wrong value at %0t: %s got %h want %h", $time, m, got, exp);
        end
    endtask
    // a wait that ran out counts as one mismatch
    task automatic print_verdict(input logic late);
        if (late) fail_count++;
        $display("checks %0d, mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // one AHB single transfer; hready is the controller's own hreadyout
    task automatic ahb(input logic wr, input logic [7:0] ofs, input logic [31:0] wd,
                       output logic [31:0] rdv);
        int n;
        haddr  <= {24'h00_0000, ofs};
        hwrite <= wr;
        htrans <= HTRANS_NONSEQ;
        hsel   <= 1'b1;
        n = 0;
        do @(posedge hclk); while (hready !== 1'b1 && ++n < 40);
        if (hready !== 1'b1) print_verdict(1'b1);
        htrans <= 2'h0;
        hsel   <= 1'b0;
        hwdata <= wd;
        n = 0;
        do @(posedge hclk); while (hready !== 1'b1 && ++n < 40);
        if (hready !== 1'b1) print_verdict(1'b1);
        rdv = hrdata;
    endtask
    task automatic host_start(input logic wr, input logic [8:0] a, input logic [31:0] wd);
        logic [31:0] dummy;
        ahb(1'b1, CTL_ADDR_OFS, {23'h00_0000, a}, dummy);
        ahb(1'b1, CTL_WDATA_OFS, wd, dummy);
        ahb(1'b1, CTL_CMD_OFS, {31'h0000_0000, wr}, dummy);
    endtask
    // poll for done, bounded, then fetch the read word
    task automatic host_finish(output logic [31:0] rdv);
        int n;
        n = 0;
        do ahb(1'b0, CTL_STAT_OFS, 32'h0000_0000, rdv); while (rdv[1] !== 1'b1 && ++n < 300);
        if (rdv[1] !== 1'b1) print_verdict(1'b1);
        ahb(1'b0, CTL_RDATA_OFS, 32'h0000_0000, rdv);
    endtask
    task automatic host_op(input logic wr, input logic [8:0] a, input logic [31:0] wd,
                           output logic [31:0] rdv);
        host_start(wr, a, wd);
        host_finish(rdv);
    endtask
    task automatic wait_owner(input logic [1:0] who);
        int n;
        n = 0;
        do @(posedge hclk); while (owner !== who && ++n < 20);
        if (owner !== who) print_verdict(1'b1);
    endtask
    // frontend posts one result word, holding the bus until it owns it
    task automatic front_wr(input logic [8:0] a, input logic [31:0] d);
        front_req   <= 1'b1;
        front_we    <= 1'b1;
        front_addr  <= a;
        front_wdata <= d;
        wait_owner(OWN_FRONT);
        @(posedge hclk);
        front_req <= 1'b0;
        front_we  <= 1'b0;
        @(posedge hclk);
    endtask
    // ********************
    // main sequence
    // ********************
    initial
    begin
        logic [31:0] exp;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        foreach (row_addr[i]) host_op(1'b1, row_addr[i], pat(row_addr[i]), rd);
        foreach (row_addr[i])
        begin
            exp = (i < 15) ? pat(row_addr[i]) : 32'h0000_0000;
            if (i == 24) exp = 32'(CODE_BYTES - REV_BYTES);
            host_op(1'b0, row_addr[i], 32'h0000_0000, rd);
            check_word(rd, exp, "table word");
        end
        // upper result words need four-wire mode; words outside the buffer stay put
        host_op(1'b1, 9'h08A, pat(9'h08A), rd);
        foreach (fe_addr[i])
        begin
            four_wire <= (i == 3);
            front_wr(fe_addr[i], ~pat(fe_addr[i]));
        end
        foreach (fe_addr[i])
        begin
            host_op(1'b0, fe_addr[i], 32'h0000_0000, rd);
            exp = (i == 0 || i == 3) ? ~pat(fe_addr[i]) : pat(fe_addr[i]);
            check_word(rd, exp, "result buffer");
        end
        // host must stall while the frontend owns the bus
        front_req <= 1'b1;
        wait_owner(OWN_FRONT);
        host_start(1'b1, 9'h0A0, pat(9'h0A0));
        repeat (20) ahb(1'b0, CTL_STAT_OFS, 32'h0000_0000, rd);
        check_word({30'h0000_0000, rd[1:0]}, 32'h0000_0001, "busy while held");
        front_req <= 1'b0;
        host_finish(rd);
        host_op(1'b0, 9'h0A0, 32'h0000_0000, rd);
        check_word(rd, pat(9'h0A0), "stalled write");
        // cpu reads, writes, then hands off to host traffic
        cpu_req <= 1'b1;
        wait_owner(OWN_CPU);
        @(posedge hclk);
        check_word(cpu_rdata, pat(9'h000), "cpu read");
        cpu_we    <= 1'b1;
        cpu_addr  <= 9'h0C1;
        cpu_wdata <= 32'hC0DE_00C1;
        @(posedge hclk);
        cpu_we  <= 1'b0;
        cpu_req <= 1'b0;
        #1 check_word({31'h0000_0000, cpu_host_start}, 32'h0000_0001, "hand-off");
        @(posedge hclk);
        host_op(1'b0, 9'h0C1, 32'h0000_0000, rd);
        check_word(rd, 32'hC0DE_00C1, "cpu write");
        // bootloader posts revisions and its own flag
        boot_load <= 1'b1;
        @(posedge hclk);
        boot_load <= 1'b0;
        host_op(1'b0, 9'h0E1, 32'h0000_0000, rd);
        check_word(rd, boot_user_rev, "user revision");
        host_op(1'b0, 9'h0E2, 32'h0000_0000, rd);
        check_word(rd, boot_vend_rev, "vendor revision");
        host_op(1'b0, 9'h0E3, 32'h0000_0000, rd);
        check_word({31'h0000_0000, rd[0]}, 32'h0000_0001, "boot flag");
        // request word is cleared once the rom has taken it
        host_op(1'b1, SYS_LO, 32'h0000_00A5, rd);
        check_word(proc_request, 32'h0000_00A5, "request word");
        rom_req_ack <= 1'b1;
        @(posedge hclk);
        rom_req_ack <= 1'b0;
        @(posedge hclk);
        check_word(proc_request, 32'h0000_0000, "request cleared");
        // a new request word in the same cycle as the rom ack must win
        cpu_req <= 1'b1;
        wait_owner(OWN_CPU);
        cpu_we      <= 1'b1;
        cpu_addr    <= SYS_LO;
        cpu_wdata   <= 32'h0000_005A;
        rom_req_ack <= 1'b1;
        @(posedge hclk);
        cpu_we      <= 1'b0;
        rom_req_ack <= 1'b0;
        @(posedge hclk);
        check_word(proc_request, 32'h0000_005A, "set beats clear");
        // second reset while the cpu holds the bus
        hresetn <= 1'b0;
        cpu_req <= 1'b0;
        repeat (2) @(posedge hclk);
        check_word({30'h0000_0000, owner}, 32'h0000_0000, "owner in reset");
        check_word(proc_request, 32'h0000_0000, "request in reset");
        hresetn <= 1'b1;
        host_op(1'b0, 9'h0E1, 32'h0000_0000, rd);
        check_word(rd, 32'h0000_0000, "revision after reset");
        print_verdict(1'b0);
    end
endmodule

// File: verilog/host_port_if.sv
// host port joining the external controller and the random access space
`timescale 1ns/1ps
interface host_port_if;
    logic        req;    // host request level
    logic        write;  // 1 write, 0 read
    logic [8:0]  addr;   // word address
    logic [31:0] wdata;  // write data
    logic        ack;    // one-cycle completion pulse
    logic [31:0] rdata;  // read data, valid with ack
    modport device (input req, write, addr, wdata, output ack, rdata);
    modport host   (output req, write, addr, wdata, input ack, rdata);
endinterface

// File: verilog/raa_host_ctrl.sv
// host end: AHB-Lite controlled master of the host port
`timescale 1ns/1ps
module raa_host_ctrl
    import raa_pkg::*;
(
    input  wire logic        hclk,      // 100 MHz clock
    input  wire logic        hresetn,   // async reset, low
    input  wire logic        hsel,      // slave select
    input  wire logic [31:0] haddr,     // byte address
    input  wire logic [1:0]  htrans,    // transfer type
    input  wire logic        hwrite,    // write phase
    input  wire logic [2:0]  hsize,     // word only
    input  wire logic [31:0] hwdata,    // write data
    input  wire logic        hready,    // bus ready
    output logic [31:0]      hrdata,    // read data
    output logic             hreadyout, // always ready
    output logic             hresp,     // always okay
    host_port_if.host        hp         // toward the device
);
    // ********************************************************
    // bus slave
    // ********************************************************
    logic        ph_wr;
    logic [7:0]  ph_ofs;
    logic [8:0]  t_addr;
    logic [31:0] t_wdata;
    logic [31:0] t_rdata;
    logic        t_write;
    hstate_t     st;
    wire take = hsel && hready && htrans == HTRANS_NONSEQ;
    // address phase latched for the data phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ph_wr  <= 1'b0;
            ph_ofs <= 8'h00;
        end
        else
        begin
            ph_wr  <= take && hwrite;
            ph_ofs <= haddr[7:0];
        end
    end
    wire cmd_go = ph_wr && ph_ofs == CTL_CMD_OFS && st != H_WAIT;
    // ********************************************************
    // request sequencer; waits while the device bus is owned elsewhere
    // ********************************************************
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            st      <= H_IDLE;
            t_addr  <= 9'h000;
            t_wdata <= 32'h0000_0000;
            t_rdata <= 32'h0000_0000;
            t_write <= 1'b0;
        end
        else
        begin
            if (ph_wr && ph_ofs == CTL_ADDR_OFS && st != H_WAIT)
                t_addr <= hwdata[8:0];
            if (ph_wr && ph_ofs == CTL_WDATA_OFS && st != H_WAIT)
                t_wdata <= hwdata;
            case (st)
                H_IDLE, H_DONE:
                    if (cmd_go)
                    begin
                        t_write <= hwdata[0];
                        st      <= H_WAIT;
                    end
                H_WAIT:
                    if (hp.ack)
                    begin
                        t_rdata <= hp.rdata;
                        st      <= H_DONE;
                    end
                default: st <= H_IDLE;
            endcase
        end
    end
    // request held until the device answers, however long it is busy
    assign hp.req   = st == H_WAIT && !hp.ack;
    assign hp.write = t_write;
    assign hp.addr  = t_addr;
    assign hp.wdata = t_wdata;
    // read mux; unknown offsets read zero
    always_comb
    begin
        case (ph_ofs)
            CTL_ADDR_OFS:  hrdata = {23'h00_0000, t_addr};
            CTL_WDATA_OFS: hrdata = t_wdata;
            CTL_CMD_OFS:   hrdata = {31'h0000_0000, t_write};
            CTL_STAT_OFS:  hrdata = {30'h0000_0000, st == H_DONE, st == H_WAIT};
            CTL_RDATA_OFS: hrdata = t_rdata;
            default:       hrdata = 32'h0000_0000;
        endcase
    end
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
endmodule

// File: verilog/raa_pkg.sv
// shared constants and types for the random access space and its host controller
package raa_pkg;
    // word address width of the random access space
    localparam int unsigned ADDR_W = 9;
    localparam int unsigned DATA_W = 32;
    // region bounds, word addresses
    localparam logic [8:0] RAM_LO     = 9'h000;
    localparam logic [8:0] RAM_HI     = 9'h0AF;
    localparam logic [8:0] RESULT_LO  = 9'h080;
    localparam logic [8:0] RESULT_HI  = 9'h09B;
    localparam logic [8:0] TEMP4W_LO  = 9'h08A;
    localparam logic [8:0] CFG_LO     = 9'h0C0;
    localparam logic [8:0] CFG_HI     = 9'h0CF;
    localparam logic [8:0] SYS_LO     = 9'h0D0;
    localparam logic [8:0] SYS_HI     = 9'h0DF;
    localparam logic [8:0] STAT_LO    = 9'h0E0;
    localparam logic [8:0] STAT_HI    = 9'h0EF;
    localparam logic [8:0] DBG_LO     = 9'h0F8;
    localparam logic [8:0] DBG_HI     = 9'h0FB;
    localparam logic [8:0] NV_LO      = 9'h100;
    localparam logic [8:0] NV_ONE_HI  = 9'h11F;
    localparam logic [8:0] NV_TWO_HI  = 9'h16B;
    localparam logic [8:0] STORED_CFG = 9'h16C;
    localparam logic [8:0] NV_HI      = 9'h17F;
    // documented single words in the non-volatile area
    localparam logic [8:0] BOOTLOADER_RELEASE_WORD   = 9'h17B;
    localparam logic [8:0] DATA_SECTION_ONE_CHECKSUM = 9'h17C;
    localparam logic [8:0] DATA_SECTION_TWO_CHECKSUM = 9'h17D;
    localparam logic [8:0] USER_CODE_CHECKSUM        = 9'h17E;
    localparam logic [8:0] VENDOR_CODE_CHECKSUM      = 9'h17F;
    // status words inside the status_result_region
    localparam logic [3:0] USER_CODE_SIZE_REG        = 4'h0;
    localparam logic [3:0] USER_CODE_REVISION_REG    = 4'h1;
    localparam logic [3:0] VENDOR_CODE_REVISION_REG  = 4'h2;
    localparam logic [3:0] BOOT_DONE_REG             = 4'h3;
    // processor_request_reg inside the system_handling_region
    localparam logic [3:0] PROCESSOR_REQUEST_REG     = 4'h0;
    // program stores, bytes
    localparam int unsigned CODE_BYTES = 4096;
    localparam int unsigned REV_BYTES  = 4;
    // controller registers, AHB byte offsets
    localparam logic [7:0] CTL_ADDR_OFS  = 8'h00;
    localparam logic [7:0] CTL_WDATA_OFS = 8'h04;
    localparam logic [7:0] CTL_CMD_OFS   = 8'h08;
    localparam logic [7:0] CTL_STAT_OFS  = 8'h0C;
    localparam logic [7:0] CTL_RDATA_OFS = 8'h10;
    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
    // bus owners of the random access space
    typedef enum logic [1:0] {OWN_HOST = 2'b00, OWN_FRONT = 2'b01, OWN_CPU = 2'b11} owner_t;
    // host controller states, gray along idle-wait-done
    typedef enum logic [1:0] {H_IDLE = 2'b00, H_WAIT = 2'b01, H_DONE = 2'b11} hstate_t;
endpackage

// File: verilog/random_access_area_map.sv
// device end: decoded random access space with owner arbitration
//
// Local design decision: the AHB-Lite register port.
`timescale 1ns/1ps
module random_access_area_map
    import raa_pkg::*;
#(
    parameter int unsigned RAM_WORDS = 176,
    parameter int unsigned NV_WORDS  = 128
)(
    input  wire logic        hclk,          // 100 MHz clock
    input  wire logic        hresetn,       // async reset, low
    host_port_if.device      hp,            // external host side
    input  wire logic        front_req,     // frontend wants the bus
    input  wire logic        front_we,      // frontend result write
    input  wire logic [8:0]  front_addr,    // frontend word address
    input  wire logic [31:0] front_wdata,   // frontend result data
    input  wire logic        four_wire,     // temperature_wiring_select
    input  wire logic        cpu_req,       // cpu wants the bus
    input  wire logic        cpu_we,        // cpu write
    input  wire logic [8:0]  cpu_addr,      // cpu word address
    input  wire logic [31:0] cpu_wdata,     // cpu write data
    output logic [31:0]      cpu_rdata,     // cpu read data
    output logic             cpu_host_start, // post-processing kicks host
    input  wire logic        boot_load,     // bootloader posts revisions
    input  wire logic [31:0] boot_user_rev, // user revision from code tail
    input  wire logic [31:0] boot_vend_rev, // vendor revision
    input  wire logic        rom_req_ack,   // rom took the request word
    output logic [31:0]      proc_request,  // request word for rom check
    output logic [1:0]       owner          // current bus owner
);
    // ********************************************************
    // arbitration
    // ********************************************************
    owner_t own;
    owner_t next_own;
    // frontend and cpu keep the bus until they drop their request; the host yields to either at once, so no access tears
    always_comb
    begin
        next_own = own;
        case (own)
            OWN_HOST:  next_own = front_req ? OWN_FRONT : (cpu_req ? OWN_CPU : OWN_HOST);
            OWN_FRONT: next_own = front_req ? OWN_FRONT : (cpu_req ? OWN_CPU : OWN_HOST);
            OWN_CPU:   next_own = cpu_req ? OWN_CPU : OWN_HOST;
            default:   next_own = OWN_HOST;
        endcase
    end
    // host is only served when nobody else holds the bus
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            own <= OWN_HOST;
        else
            own <= next_own;
    end
    assign owner = own;

    // ********************************************************
    // access selection
    // ********************************************************
    logic        host_pend;
    wire         host_go  = hp.req && !host_pend && own == OWN_HOST && next_own == OWN_HOST;
    wire         sel_we   = (own == OWN_FRONT) ? front_we :
                            (own == OWN_CPU) ? cpu_we : (host_go && hp.write);
    wire  [8:0]  sel_addr = (own == OWN_FRONT) ? front_addr :
                            (own == OWN_CPU) ? cpu_addr : hp.addr;
    wire  [31:0] sel_wd   = (own == OWN_FRONT) ? front_wdata :
                            (own == OWN_CPU) ? cpu_wdata : hp.wdata;
    // region decode over one word space
    wire in_ram  = sel_addr <= RAM_HI;
    wire in_cfg  = sel_addr >= CFG_LO && sel_addr <= CFG_HI;
    wire in_sys  = sel_addr >= SYS_LO && sel_addr <= SYS_HI;
    wire in_stat = sel_addr >= STAT_LO && sel_addr <= STAT_HI;
    wire in_dbg  = sel_addr >= DBG_LO && sel_addr <= DBG_HI;
    wire in_nv   = sel_addr >= NV_LO && sel_addr <= NV_HI;
    // host may not write status or debug words
    wire ro_hit  = (in_stat || in_dbg) && own == OWN_HOST;
    // three-wire runs leave the upper result words untouched
    wire fe_skip = own == OWN_FRONT && !four_wire &&
                   sel_addr >= TEMP4W_LO && sel_addr <= RESULT_HI;
    wire fe_ok   = own != OWN_FRONT ||
                   (sel_addr >= RESULT_LO && sel_addr <= RESULT_HI);
    wire wr_en   = sel_we && !ro_hit && !fe_skip && fe_ok;

    // ********************************************************
    // storage
    // ********************************************************
    logic [31:0] ram  [RAM_WORDS];
    logic [31:0] cfg  [16];
    logic [31:0] sys  [16];
    // nvram words, never gated off, no power-down path exists
    logic [31:0] nv   [NV_WORDS];
    logic [31:0] user_rev;
    logic [31:0] vend_rev;
    logic        boot_done;
    wire  [7:0]  ram_i = sel_addr[7:0];
    wire  [6:0]  nv_i  = sel_addr[6:0];
    // memories carry no reset; contents are firmware-defined
    always_ff @(posedge hclk)
    begin
        if (wr_en && in_ram)
            ram[ram_i] <= sel_wd;
        if (wr_en && in_cfg)
            cfg[sel_addr[3:0]] <= sel_wd;
        if (wr_en && in_nv)
            nv[nv_i] <= sel_wd;
    end
    // system words; rom ack clears the request unless a new write lands
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            for (int i = 0; i < 16; i++)
                sys[i] <= 32'h0000_0000;
        end
        else
        begin
            if (rom_req_ack)
                sys[PROCESSOR_REQUEST_REG] <= 32'h0000_0000;
            if (wr_en && in_sys)
                sys[sel_addr[3:0]] <= sel_wd;
        end
    end
    assign proc_request = sys[PROCESSOR_REQUEST_REG];
    // revisions are captured only when the bootloader posts them
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            user_rev  <= 32'h0000_0000;
            vend_rev  <= 32'h0000_0000;
            boot_done <= 1'b0;
        end
        else if (boot_load)
        begin
            user_rev  <= boot_user_rev;
            vend_rev  <= boot_vend_rev;
            boot_done <= 1'b1;
        end
    end

    // ********************************************************
    // read path
    // ********************************************************
    logic [31:0] rd;
    // code stores sit elsewhere; no address here reaches them
    always_comb
    begin
        rd = 32'h0000_0000;
        if (in_ram)
            rd = ram[ram_i];
        else if (in_cfg)
            rd = cfg[sel_addr[3:0]];
        else if (in_sys)
            rd = sys[sel_addr[3:0]];
        else if (in_nv)
            rd = nv[nv_i];
        else if (in_stat)
        begin
            case (sel_addr[3:0])
                USER_CODE_SIZE_REG:       rd = 32'(CODE_BYTES - REV_BYTES);
                USER_CODE_REVISION_REG:   rd = user_rev;
                VENDOR_CODE_REVISION_REG: rd = vend_rev;
                BOOT_DONE_REG:            rd = {31'h0000_0000, boot_done};
                default:                  rd = 32'h0000_0000;
            endcase
        end
    end
    // host answer one cycle after acceptance
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            host_pend <= 1'b0;
            hp.rdata  <= 32'h0000_0000;
            cpu_rdata <= 32'h0000_0000;
        end
        else
        begin
            host_pend <= host_go;
            if (host_go)
                hp.rdata <= rd;
            if (own == OWN_CPU)
                cpu_rdata <= rd;
        end
    end
    assign hp.ack = host_pend;
    // post-processing may hand the bus back to start host traffic
    assign cpu_host_start = own == OWN_CPU && !cpu_req;
endmodule
